// ==== dv/bqf_filter_bank_assertions.sv ====
// Port checker for the filter bank
`timescale 1ns/100ps
module bqf_filter_bank_assertions
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sampleInValid,
   input wire logic [95:0] sampleIn,
   input wire logic        sampleOutValid,
   input wire logic [95:0] sampleOut
);
   logic [4:0] busyCnt_r;
   logic       doneExp_r;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   //////////////////////////////////////////////////////////////////////
   // Tracks the 17-edge run of an accepted sample
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         busyCnt_r <= 5'h00;
         doneExp_r <= 1'b0;
      end
      else
      begin
         if (busyCnt_r == 5'h00)
            busyCnt_r <= sampleInValid ? 5'h11 : 5'h00;
         else
            busyCnt_r <= busyCnt_r - 5'h01;
         doneExp_r <= (busyCnt_r == 5'h01);
      end
   end
   //////////////////////////////////////////////////////////////////////
   // Bus answer and result timing
   AST_PREADY_AFTER_SETUP: assert property
      (psel && !penable |=> pready) else $error("no answer after setup");
   AST_PREADY_CAUSE: assert property
      (pready |-> $past(psel && !penable)) else $error("stray answer");
   AST_PREADY_ONE: assert property
      (pready |=> !pready) else $error("answer longer than a cycle");
   AST_RDATA_IDLE: assert property
      (!pready |-> prdata == 32'h0) else $error("read data outside access");
   AST_ERR_WITH_READY: assert property
      (pslverr |-> pready) else $error("error without answer");
   AST_OUT_TIMING: assert property
      (sampleOutValid == doneExp_r) else $error("result at wrong edge");
   AST_OUT_LATENCY: assert property
      (sampleInValid && busyCnt_r == 5'h00 |-> ##18 sampleOutValid)
      else $error("result missing");
   AST_OUT_PULSE: assert property
      (sampleOutValid |=> !sampleOutValid[*2]) else $error("long result");
   AST_OUT_HOLD: assert property
      (!sampleOutValid |-> $stable(sampleOut)) else $error("output moved");
   COV_READ: cover property (pready && !pwrite);
   COV_ERR: cover property (pready && pslverr);
   COV_RESULT: cover property (sampleOutValid);
endmodule

bind bqf_filter_bank bqf_filter_bank_assertions bqf_filter_bank_assertions_inst
(
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sampleInValid(sampleInValid), .sampleIn(sampleIn),
   .sampleOutValid(sampleOutValid), .sampleOut(sampleOut)
);

// ==== dv/bqf_filter_bank_test.sv ====
// Self-checking bench for the filter bank
`timescale 1ns/100ps
`include "bqf_map.svh"
`define CHK(nm, e, g) \
   begin \
      n_tests++; \
      if ((g) !== (e)) \
      begin \
         n_fail++; \
         $display("ERROR %s exp %h got %h", nm, e, g); \
      end \
   end
module bqf_filter_bank_test;
   logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic        sampleInValid = 0, pready, pslverr, sampleOutValid;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, seed = 32'h4d9e, coef[1:12];
   logic [95:0] sampleIn = 0, sampleOut, exS;
   logic [32:0] exR;
   logic [32:0] rdQ[$];
   logic [95:0] smpQ[$];
   logic [1:0]  alloc = 2'h2, hpf = 2'h1;
   logic        twoCh = 0, bank = 0;
   int          n_fail = 0, n_tests = 0;
   logic [31:0] iirN0 = `BQF_IIR_N0_RST, iirN1 = 0, iirD1 = 0;
   logic [23:0] ix1[4] = '{4{24'h0}}, iy1[4] = '{4{24'h0}};

   always #10 clk = ~clk;

   bqf_filter_bank bqf_filter_bank_inst
   (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sampleInValid(sampleInValid),
      .sampleIn(sampleIn), .sampleOutValid(sampleOutValid),
      .sampleOut(sampleOut)
   );
   //////////////////////////////////////////////////////////////////////
   // Stimulus helpers and reference model
   function logic [95:0] rs();
      logic [95:0] v;
      repeat (3)
      begin
         seed ^= seed << 13;
         seed ^= seed >> 17;
         seed ^= seed << 5;
         v = {v[63:0], seed};
      end
      return v;
   endfunction

   function logic [11:0] ca(int b, int k);
      return 12'(32'h100 + 20 * (b - 1) + 4 * k);
   endfunction

   // Q31 gain with round to nearest
   function logic [23:0] mul(logic [23:0] x, logic [31:0] c);
      longint p;
      p = longint'($signed(x)) * longint'($signed(c)) + 64'sh4000_0000;
      return 24'(p >>> 31);
   endfunction

   // First-order section, one rounding, history kept per channel
   function logic [23:0] iir(int c, logic [23:0] x);
      longint p;
      p = longint'($signed(x)) * longint'($signed(iirN0))
        + longint'($signed(ix1[c])) * longint'($signed(iirN1))
        + longint'($signed(iy1[c])) * longint'($signed(iirD1))
        + 64'sh4000_0000;
      ix1[c] = x;
      iy1[c] = 24'(p >>> 31);
      return iy1[c];
   endfunction

   function logic [95:0] model(logic [95:0] s);
      logic [23:0] y[4];
      int c;
      for (c = 0; c < 4; c++)
         y[c] = (hpf == 0) ? iir(c, s[24*c+:24]) : s[24*c+:24];
      for (int b = 1; b <= 12; b++)
      begin
         c = (b - 1) % 4;
         if ((b - 1) / 4 < alloc)
            y[c] = mul(y[c], coef[(twoCh && bank && c < 2) ? b + 2 : b]);
      end
      return {y[3], y[2], y[1], y[0]};
   endfunction

   task wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task apb(logic w, logic [11:0] a, logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      i = 0;
      do
      begin
         @(posedge clk);
         i++;
      end
      while (!pready && i < 20);
      if (!pready)
      begin
         n_fail++;
         wrap_up();
      end
      psel <= 0;
      penable <= 0;
   endtask

   task rd(logic [11:0] a, logic [32:0] e);
      rdQ.push_back(e);
      apb(0, a, 0);
   endtask

   task cfg();
      apb(1, `BQF_CFG_OFS, {26'h0, hpf, alloc, bank, twoCh});
   endtask

   // One sample; dbl adds a pulse while busy
   task smp(logic [95:0] x, logic dbl = 0);
      int i;
      smpQ.push_back(model(x));
      @(posedge clk);
      sampleInValid <= 1;
      sampleIn <= x;
      @(posedge clk);
      sampleInValid <= 0;
      if (dbl)
      begin
         @(posedge clk);
         sampleInValid <= 1;
         @(posedge clk);
         sampleInValid <= 0;
      end
      for (i = 0; i < 30 && !sampleOutValid; i++)
         @(negedge clk);
      if (i == 30)
      begin
         n_fail++;
         wrap_up();
      end
   endtask
   //////////////////////////////////////////////////////////////////////
   // Result watcher
   always @(posedge clk)
   begin
      if (psel && penable && pready && !pwrite)
      begin
         exR = rdQ.pop_front();
         `CHK("register read", exR, {pslverr, prdata})
      end
      if (sampleOutValid)
      begin
         exS = smpQ.pop_front();
         `CHK("samples", exS, sampleOut)
      end
   end
   //////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 0;
      for (int b = 1; b <= 12; b++)
         coef[b] = 32'h7fff_ffff;
      rd(`BQF_CFG_OFS, 33'h18);
      rd(`BQF_IIR_N0_OFS, 33'h07ff_ffff);
      rd(`BQF_IIR_N1_OFS, 33'h0);
      rd(`BQF_IIR_D1_OFS, 33'h0);
      rd(ca(12, 0), 33'h7fff_ffff);
      rd(ca(12, 4), 33'h0);
      rd(12'h008, 33'h1_0000_0000);
      smp(rs());
      foreach (coef[b])
         if (b % 4 != 0 && b != 6 && b != 7 && b != 11)
         begin
            coef[b] = (b == 3) ? 32'h2000_0000 : 32'h4000_0000;
            apb(1, ca(b, 0), coef[b]);
            rd(ca(b, 0), {1'b0, coef[b]});
         end
      for (int i = 0; i < 4; i++)
      begin
         alloc = 2'(i);
         cfg();
         smp(rs());
         smp(rs());
      end
      twoCh = 1;
      alloc = 2'h1;
      for (int i = 0; i < 2; i++)
      begin
         bank = 1'(i ^ 1);
         cfg();
         smp(rs());
      end
      twoCh = 0;
      hpf = 2'h0;
      alloc = 2'h0;
      cfg();
      smp(rs());
      smp(rs(), 1);
      iirN1 = 32'h4000_0000;
      iirD1 = 32'h2000_0000;
      apb(1, `BQF_IIR_N1_OFS, iirN1);
      apb(1, `BQF_IIR_D1_OFS, iirD1);
      smp(rs());
      smp(rs());
      rd(`BQF_STAT_OFS, 33'h4);
      apb(1, `BQF_STAT_OFS, 32'h4);
      rd(`BQF_STAT_OFS, 33'h0);
      @(posedge clk);
      `CHK("results left", 0, rdQ.size() + smpQ.size())
      wrap_up();
   end
endmodule

// ==== logic/bqf_filter_bank.sv ====
// Playback first-order IIR and twelve-biquad filter bank with APB slave
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "bqf_map.svh"

module bqf_filter_bank
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sampleInValid,
   input  wire logic [95:0] sampleIn,
   output logic             sampleOutValid,
   output logic      [95:0] sampleOut
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [1:0]          biquadAllocCfg_r;
   logic [1:0]          highpassCutoffSel_r;
   logic                twoChannel_r;
   logic                bankSel_r;
   logic                bankLive_r;
   logic                overrun_r;
   bqf_pkg::bqf_coef_t  numeratorTap0_r;
   bqf_pkg::bqf_coef_t  numeratorTap1_r;
   bqf_pkg::bqf_coef_t  denominatorTap1_r;
   bqf_pkg::bqf_coef_t  coef_r [`BQF_NUM_COEF];
   bqf_pkg::bqf_sample_t work_r [4];
   bqf_pkg::bqf_sample_t bqX1_r [12];
   bqf_pkg::bqf_sample_t bqX2_r [12];
   bqf_pkg::bqf_sample_t bqY1_r [12];
   bqf_pkg::bqf_sample_t bqY2_r [12];
   bqf_pkg::bqf_sample_t iirX1_r [4];
   bqf_pkg::bqf_sample_t iirY1_r [4];
   bqf_pkg::bqf_state_e state_r;
   logic [3:0]          step_r;

   logic                apbSetup;
   logic                apbWrite;
   logic                coefHit;
   logic [5:0]          coefIdx;
   logic [31:0]         rdVal;
   logic                rdErr;
   logic                isIir;
   logic [3:0]          bqIdx;
   logic [1:0]          chan;
   logic                stageOn;
   logic                useAlt;
   logic [3:0]          coefSet;
   logic [5:0]          coefBase;
   logic [124:0]        tapVals;
   logic [159:0]        tapCoefs;
   logic [23:0]         macOut;
   bqf_pkg::bqf_sample_t curX;

   ////////////////////////////////////////////////////////////////////////
   // APB decode

   // Request phases and the coefficient window
   assign apbSetup = psel & ~penable;
   assign apbWrite = psel & penable & pready & pwrite;
   assign coefHit  = (paddr[11:8] == `BQF_COEF_PAGE) &&
                     (paddr[7:0] < `BQF_COEF_END) && (paddr[1:0] == 2'b00);
   assign coefIdx  = paddr[7:2];

   // Read mux, unmapped addresses answer with an error
   always_comb
   begin
      rdVal = 32'h0;
      rdErr = 1'b0;
      if (coefHit)
      begin
         rdVal = coef_r[coefIdx];
      end
      else
      begin
         case (paddr)
            `BQF_CFG_OFS:
               rdVal = {26'h0, highpassCutoffSel_r, biquadAllocCfg_r,
                        bankSel_r, twoChannel_r};
            `BQF_STAT_OFS:
               rdVal = {29'h0, overrun_r, bankLive_r,
                        state_r != bqf_pkg::BQF_IDLE};
            `BQF_IIR_N0_OFS: rdVal = numeratorTap0_r;
            `BQF_IIR_N1_OFS: rdVal = numeratorTap1_r;
            `BQF_IIR_D1_OFS: rdVal = denominatorTap1_r;
            default:         rdErr = 1'b1;
         endcase
      end
   end

   // One wait-free access phase per request
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= apbSetup;
         prdata  <= (apbSetup & ~pwrite) ? rdVal : 32'h0;
         pslverr <= apbSetup & rdErr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control and coefficient registers

   // Configuration register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         twoChannel_r        <= 1'b0;
         bankSel_r           <= 1'b0;
         biquadAllocCfg_r    <= 2'b10;
         highpassCutoffSel_r <= 2'b01;
      end
      else if (apbWrite && paddr == `BQF_CFG_OFS)
      begin
         twoChannel_r        <= pwdata[`BQF_CFG_TWOCH];
         bankSel_r           <= pwdata[`BQF_CFG_BANK];
         biquadAllocCfg_r    <= pwdata[`BQF_CFG_BQ_LO +: 2];
         highpassCutoffSel_r <= pwdata[`BQF_CFG_HPF_LO +: 2];
      end
   end

   // First-order section coefficients
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         numeratorTap0_r   <= `BQF_IIR_N0_RST;
         numeratorTap1_r   <= `BQF_IIR_N1_RST;
         denominatorTap1_r <= `BQF_IIR_D1_RST;
      end
      else if (apbWrite)
      begin
         if (paddr == `BQF_IIR_N0_OFS)
         begin
            numeratorTap0_r <= pwdata;
         end
         if (paddr == `BQF_IIR_N1_OFS)
         begin
            numeratorTap1_r <= pwdata;
         end
         if (paddr == `BQF_IIR_D1_OFS)
         begin
            denominatorTap1_r <= pwdata;
         end
      end
   end

   // Biquad coefficient store, five words per section
   for (genvar e = 0; e < `BQF_NUM_COEF; e++)
   begin : gCoef
      always_ff @(posedge clk or posedge rst)
      begin
         if (rst)
         begin
            coef_r[e] <= (e % `BQF_COEF_PER == 0) ?
                         `BQF_BQ_N0_RST : 32'h0;
         end
         else if (apbWrite && coefHit && coefIdx == 6'(e))
         begin
            coef_r[e] <= pwdata;
         end
      end
   end

   // Overrun flag, a new sample beats a same-cycle clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         overrun_r <= 1'b0;
      end
      else if (sampleInValid && state_r != bqf_pkg::BQF_IDLE)
      begin
         overrun_r <= 1'b1;
      end
      else if (apbWrite && paddr == `BQF_STAT_OFS &&
               pwdata[`BQF_STAT_OVR])
      begin
         overrun_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Stage selection and arithmetic

   // Steps 0-3 run the first-order section, 4-15 biquads 1-12
   always_comb
   begin
      isIir    = step_r < `BQF_IIR_STEPS;
      bqIdx    = step_r - `BQF_IIR_STEPS;
      chan     = step_r[1:0];
      curX     = work_r[chan];
      useAlt   = twoChannel_r & bankLive_r & ~chan[1];
      coefSet  = useAlt ? bqIdx + 4'd2 : bqIdx;
      coefBase = 6'(coefSet) * 6'd5;
      if (isIir)
      begin
         stageOn = highpassCutoffSel_r == `BQF_HPF_PROG;
         tapVals = {25'h0, {iirY1_r[chan][23], iirY1_r[chan]},
                    25'h0, {iirX1_r[chan][23], iirX1_r[chan]},
                    {curX[23], curX}};
         tapCoefs = {32'h0, denominatorTap1_r, 32'h0,
                     numeratorTap1_r, numeratorTap0_r};
      end
      else
      begin
         stageOn = bqIdx[3:2] < biquadAllocCfg_r;
         tapVals = {{bqY2_r[bqIdx][23], bqY2_r[bqIdx]},
                    {bqY1_r[bqIdx], 1'b0},
                    {bqX2_r[bqIdx][23], bqX2_r[bqIdx]},
                    {bqX1_r[bqIdx], 1'b0},
                    {curX[23], curX}};
         tapCoefs = {coef_r[coefBase + 6'd4], coef_r[coefBase + 6'd3],
                     coef_r[coefBase + 6'd2], coef_r[coefBase + 6'd1],
                     coef_r[coefBase]};
      end
   end

   // Shared multiply-accumulate for every stage
   bqf_tap_mac uMac
   (
      .tapVals  (tapVals),
      .tapCoefs (tapCoefs),
      .result   (macOut)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sequencer

   // One sample set per pass of sixteen steps
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_r    <= bqf_pkg::BQF_IDLE;
         step_r     <= 4'h0;
         bankLive_r <= 1'b0;
      end
      else
      begin
         case (state_r)
            bqf_pkg::BQF_IDLE:
               if (sampleInValid)
               begin
                  state_r    <= bqf_pkg::BQF_RUN;
                  step_r     <= 4'h0;
                  bankLive_r <= bankSel_r;
               end
            bqf_pkg::BQF_RUN:
            begin
               step_r <= step_r + 4'h1;
               if (step_r == `BQF_LAST_STEP)
               begin
                  state_r <= bqf_pkg::BQF_DONE;
               end
            end
            bqf_pkg::BQF_DONE:
               state_r <= bqf_pkg::BQF_IDLE;
            default:
               state_r <= bqf_pkg::BQF_IDLE;
         endcase
      end
   end

   // Working samples, each active stage feeds the next
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int c = 0; c < 4; c++)
         begin
            work_r[c] <= 24'h0;
         end
      end
      else if (state_r == bqf_pkg::BQF_IDLE && sampleInValid)
      begin
         for (int c = 0; c < 4; c++)
         begin
            work_r[c] <= sampleIn[c*24 +: 24];
         end
      end
      else if (state_r == bqf_pkg::BQF_RUN && stageOn)
      begin
         work_r[chan] <= macOut;
      end
   end

   // Section histories, advanced only when the section ran
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int b = 0; b < 12; b++)
         begin
            bqX1_r[b] <= 24'h0;
            bqX2_r[b] <= 24'h0;
            bqY1_r[b] <= 24'h0;
            bqY2_r[b] <= 24'h0;
         end
         for (int c = 0; c < 4; c++)
         begin
            iirX1_r[c] <= 24'h0;
            iirY1_r[c] <= 24'h0;
         end
      end
      else if (state_r == bqf_pkg::BQF_RUN && stageOn)
      begin
         if (isIir)
         begin
            iirX1_r[chan] <= curX;
            iirY1_r[chan] <= macOut;
         end
         else
         begin
            bqX1_r[bqIdx] <= curX;
            bqX2_r[bqIdx] <= bqX1_r[bqIdx];
            bqY1_r[bqIdx] <= macOut;
            bqY2_r[bqIdx] <= bqY1_r[bqIdx];
         end
      end
   end

   // Result presented for one cycle after the last step
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sampleOutValid <= 1'b0;
         sampleOut      <= 96'h0;
      end
      else
      begin
         sampleOutValid <= state_r == bqf_pkg::BQF_DONE;
         if (state_r == bqf_pkg::BQF_DONE)
         begin
            sampleOut <= {work_r[3], work_r[2], work_r[1], work_r[0]};
         end
      end
   end

endmodule

// ==== logic/bqf_map.svh ====
// Register offsets, field positions, reset values and step counts
`ifndef BQF_MAP_SVH
`define BQF_MAP_SVH

// Register byte offsets
`define BQF_CFG_OFS      12'h000
`define BQF_STAT_OFS     12'h004
`define BQF_IIR_N0_OFS   12'h010
`define BQF_IIR_N1_OFS   12'h014
`define BQF_IIR_D1_OFS   12'h018
`define BQF_COEF_PAGE    4'h1
`define BQF_COEF_END     8'hf0

// Configuration fields
`define BQF_CFG_TWOCH    0
`define BQF_CFG_BANK     1
`define BQF_CFG_BQ_LO    2
`define BQF_CFG_HPF_LO   4
`define BQF_CFG_RST      32'h0000_0018

// Status fields
`define BQF_STAT_BUSY    0
`define BQF_STAT_BANK    1
`define BQF_STAT_OVR     2

// Coefficient reset values
`define BQF_IIR_N0_RST   32'h07ff_ffff
`define BQF_IIR_N1_RST   32'h0000_0000
`define BQF_IIR_D1_RST   32'h0000_0000
`define BQF_BQ_N0_RST    32'h7fff_ffff

// Coefficient store layout and step counts
`define BQF_NUM_COEF     60
`define BQF_COEF_PER     5
`define BQF_IIR_STEPS    4'd4
`define BQF_LAST_STEP    4'd15
`define BQF_HPF_PROG     2'b00
`define BQF_FRAC         31
`define BQF_ROUND        64'sh0000_0000_4000_0000

`endif

// ==== logic/bqf_pkg.sv ====
// Types shared by the filter bank
package bqf_pkg;

   typedef enum logic [1:0]
   {
      BQF_IDLE = 2'b00,
      BQF_RUN  = 2'b01,
      BQF_DONE = 2'b10
   } bqf_state_e;

   typedef logic signed [23:0] bqf_sample_t;
   typedef logic signed [31:0] bqf_coef_t;

endpackage

// ==== logic/bqf_tap_mac.sv ====
// Five-tap multiply-accumulate with rounding and saturation
`timescale 1ns/100ps
`include "bqf_map.svh"

module bqf_tap_mac
(
   input  wire logic [124:0] tapVals,
   input  wire logic [159:0] tapCoefs,
   output logic      [23:0]  result
);

   localparam logic signed [63:0] MAXV = 64'sh0000_0000_007f_ffff;
   localparam logic signed [63:0] MINV = 64'shffff_ffff_ff80_0000;

   logic signed [63:0] prod [5];
   logic signed [63:0] acc;
   logic signed [63:0] shifted;

   // One product per tap, each at full width
   for (genvar t = 0; t < 5; t++)
   begin : gTap
      assign prod[t] = 64'($signed(tapVals[t*25 +: 25]) *
                           $signed(tapCoefs[t*32 +: 32]));
   end

   // Sum, round at the 2^31 point, clip to the sample range
   always_comb
   begin
      acc = `BQF_ROUND;
      for (int i = 0; i < 5; i++)
      begin
         acc = acc + prod[i];
      end
      shifted = acc >>> `BQF_FRAC;
      if (shifted > MAXV)
      begin
         result = 24'h7fffff;
      end
      else if (shifted < MINV)
      begin
         result = 24'h800000;
      end
      else
      begin
         result = shifted[23:0];
      end
   end

endmodule
